// file: inc/psf_defs.vh
`ifndef PSF_DEFS_VH
`define PSF_DEFS_VH
// Status word bit positions
`define PSF_SYS_MODE      31
`define PSF_IE_STACK      30
`define PSF_ERR_STACK     29
`define PSF_SEM_VAL       28
`define PSF_SEM_PTR_HI    27
`define PSF_SEM_PTR_LO    23
`define PSF_IDLE          22
`define PSF_CLK_ENTRY     21
`define PSF_IE_RECIP      20
`define PSF_ERR_RECIP     19
`define PSF_FLT_EN        18
`define PSF_IE_FLT        17
`define PSF_ERR_FLT       16
`define PSF_IE_RANGE      15
`define PSF_ERR_WR_RANGE  14
`define PSF_ERR_RD_RANGE  13
`define PSF_IE_LMEM       12
`define PSF_ERR_LMEM_HI   11
`define PSF_ERR_LMEM_LO   8
`define PSF_IE_EXIT       7
`define PSF_EXIT_FLAG     6
`define PSF_EXIT_PARM_HI  5
// Reset value of the whole status word
`define PSF_RESET_VAL     32'h0040_0000
`endif

// file: design/psf_status_flags.v
// Behaviour
// - System-mode bit stored only, drives nothing
// - Call on stack parity flag and enable
// - Stack parity sets flag, pulses error capture
// - Semaphore bit follows own program only
// - Pointer selects one of 32 semaphores
// - Small systems use upper four pointer bits
// - Idle bit updated every clock
// - Idle after exit or stop, until restart
// - Clock entry enable gates clock load
// - Reciprocal table parity sets its flag
// - Call on reciprocal flag and enable
// - Float check instructions clear/set enable
// - Float range error flag, call when enabled
// - Range enable pairs either range flag
// - Write range error sets flag, blocks write
// - Read range error sets flag, zero data
// - Range disable instruction clears range flags
// - Four local memory parity flags, one per module
// - Call on any parity flag with enable
// - Exit sets flag; call with enable, idle
// - Program_exit_instr field into low six bits
`timescale 1ns/1ps
`include "psf_defs.vh"
module psf_status_flags (
  input  wire        ref_clk,          // 50 MHz clock
  input  wire        rst,              // Async reset, active high
  input  wire        clkEn,            // Freezes all state when low
  input  wire        fgWrEn,           // Foreground write strobe
  input  wire [31:0] fgWrData,         // Foreground write data
  output reg  [31:0] statusRdData,     // Status word as read
  output reg         chanCallReq,      // Channel call response request
  input  wire        smallSystem,      // One to eight processors
  input  wire        fgStop,           // Foreground stops processor
  input  wire        fgRestart,        // Foreground restarts processor
  input  wire        cpuActive,        // Executing or own refs in flight
  input  wire        exitInstr,        // program_exit_instr issued
  input  wire [5:0]  exitJk,           // jk field of exit
  input  wire        stackParityErr,   // Instruction stack parity error
  input  wire        recipParityErr,   // Reciprocal table parity error
  input  wire        fltRangeErr,      // Float result out of range
  input  wire        floatCheckDisInstr, // float_check_disable_instr
  input  wire        floatCheckEnInstr,  // float_check_enable_instr
  input  wire        rangeCheckDisInstr, // range_check_disable_instr
  input  wire        rangeCheckEnInstr,  // range_check_enable_instr
  input  wire        cmWrReq,          // Common memory write request
  input  wire        cmRdReq,          // Common memory read request
  input  wire        cmAddrOutRange,   // Address exceeds assigned range
  input  wire [63:0] cmRdDataIn,       // Read data from memory
  output reg         cmWrAllow,        // Write passed to memory
  output reg  [63:0] cmRdDataOut,      // Read data, zero on range error
  input  wire [3:0]  lmemParityErr,    // Local memory parity per module
  input  wire        semOwnSet,        // Own program sets semaphore
  input  wire        semOwnClr,        // Own program clears semaphore
  input  wire        semSetIn,         // Semaphore op request
  output reg  [4:0]  semSelect,        // Selected semaphore index
  output reg         semWrSel,         // Apply op to selected flag only
  input  wire        clockLoadInstr,   // clock_load_instr issued
  output reg         clockLoadEn,      // Load clock register
  output reg         fltCheckEnable,   // Float range tests enabled
  output reg         errCapture        // Capture stack error detail
);

  // Architectural word and its helpers
  reg  [31:0] status_ff;             // Status word as held
  reg  [31:0] nxt_status;            // Assembled next word
  reg         idle_ff;               // Stopped or exited latch
  reg         nxt_idle;              // Next value of the latch
  reg         nxt_call;              // Next channel call request
  reg  [4:0]  nxt_semSelect;         // Next semaphore index
  reg  [63:0] nxt_cmRdData;          // Next read data to processor

  // Per-field next values, one process per field or related group
  reg         nxt_sysMode;           // Bit 31
  reg         nxt_ieStack;           // Bit 30
  reg         nxt_errStack;          // Bit 29
  reg         nxt_semVal;            // Bit 28
  reg  [4:0]  nxt_semPtr;            // Bits 27:23
  reg         nxt_idleBit;           // Bit 22
  reg         nxt_clkEntry;          // Bit 21
  reg         nxt_ieRecip;           // Bit 20
  reg         nxt_errRecip;          // Bit 19
  reg         nxt_fltEn;             // Bit 18
  reg         nxt_ieFlt;             // Bit 17
  reg         nxt_errFlt;            // Bit 16
  reg         nxt_ieRange;           // Bit 15
  reg         nxt_errWrRange;        // Bit 14
  reg         nxt_errRdRange;        // Bit 13
  reg         nxt_ieLmem;            // Bit 12
  wire [3:0]  nxt_errLmem;           // Bits 11:8
  reg         nxt_ieExit;            // Bit 7
  reg         nxt_exitFlag;          // Bit 6
  reg  [5:0]  nxt_exitParm;          // Bits 5:0

  // Qualified memory range events
  wire        wrRangeHit;            // Write beyond assigned range
  wire        rdRangeHit;            // Read beyond assigned range

  assign wrRangeHit = cmWrReq & cmAddrOutRange;
  assign rdRangeHit = cmRdReq & cmAddrOutRange;

  // Idle tracking: stop or exit parks it until restart
  // Deadstart counts as stopped, so the latch resets set
  always @* begin
    nxt_idle = idle_ff;
    if (fgRestart)
      nxt_idle = 1'b0;
    if (exitInstr || fgStop)
      nxt_idle = 1'b1;
  end

  // Idle bit recomputed every clock; latch or no activity
  always @* begin
    nxt_idleBit = nxt_idle | ~cpuActive;
  end

  // System mode: stored for software only, drives nothing
  always @* begin
    if (fgWrEn)
      nxt_sysMode = fgWrData[`PSF_SYS_MODE];
    else
      nxt_sysMode = status_ff[`PSF_SYS_MODE];
  end

  // Interrupt enables and the clock entry enable, owned by the foreground side
  always @* begin
    if (fgWrEn) begin
      nxt_ieStack  = fgWrData[`PSF_IE_STACK];
      nxt_clkEntry = fgWrData[`PSF_CLK_ENTRY];
      nxt_ieRecip  = fgWrData[`PSF_IE_RECIP];
      nxt_ieFlt    = fgWrData[`PSF_IE_FLT];
      nxt_ieLmem   = fgWrData[`PSF_IE_LMEM];
      nxt_ieExit   = fgWrData[`PSF_IE_EXIT];
    end else begin
      nxt_ieStack  = status_ff[`PSF_IE_STACK];
      nxt_clkEntry = status_ff[`PSF_CLK_ENTRY];
      nxt_ieRecip  = status_ff[`PSF_IE_RECIP];
      nxt_ieFlt    = status_ff[`PSF_IE_FLT];
      nxt_ieLmem   = status_ff[`PSF_IE_LMEM];
      nxt_ieExit   = status_ff[`PSF_IE_EXIT];
    end
  end

  // Stack parity flag; the hardware set beats a clearing write
  always @* begin
    nxt_errStack = fgWrEn ? fgWrData[`PSF_ERR_STACK] : status_ff[`PSF_ERR_STACK];
    if (stackParityErr)
      nxt_errStack = 1'b1;
  end

  // Semaphore copy: only this program's own ops move it
  // Foreground writes cannot disturb it, others' ops never reach it
  always @* begin
    nxt_semVal = status_ff[`PSF_SEM_VAL];
    if (semOwnSet)
      nxt_semVal = 1'b1;
    else if (semOwnClr)
      nxt_semVal = 1'b0;
  end

  // Semaphore pointer, written by the foreground only
  always @* begin
    if (fgWrEn)
      nxt_semPtr = fgWrData[`PSF_SEM_PTR_HI:`PSF_SEM_PTR_LO];
    else
      nxt_semPtr = status_ff[`PSF_SEM_PTR_HI:`PSF_SEM_PTR_LO];
  end

  // Reciprocal table parity flag, sticky until rewritten
  always @* begin
    nxt_errRecip = fgWrEn ? fgWrData[`PSF_ERR_RECIP] : status_ff[`PSF_ERR_RECIP];
    if (recipParityErr)
      nxt_errRecip = 1'b1;
  end

  // Float range test enable; enable wins if both arrive together
  always @* begin
    nxt_fltEn = fgWrEn ? fgWrData[`PSF_FLT_EN] : status_ff[`PSF_FLT_EN];
    if (floatCheckDisInstr)
      nxt_fltEn = 1'b0;
    if (floatCheckEnInstr)
      nxt_fltEn = 1'b1;
  end

  // Float range error flag
  always @* begin
    nxt_errFlt = fgWrEn ? fgWrData[`PSF_ERR_FLT] : status_ff[`PSF_ERR_FLT];
    if (fltRangeErr)
      nxt_errFlt = 1'b1;
  end

  // Memory range enable, also moved by the range instructions
  always @* begin
    nxt_ieRange = fgWrEn ? fgWrData[`PSF_IE_RANGE] : status_ff[`PSF_IE_RANGE];
    if (rangeCheckDisInstr)
      nxt_ieRange = 1'b0;
    if (rangeCheckEnInstr)
      nxt_ieRange = 1'b1;
  end

  // Range error flags; a fresh error outlives a same-cycle clear
  always @* begin
    nxt_errWrRange = fgWrEn ? fgWrData[`PSF_ERR_WR_RANGE] : status_ff[`PSF_ERR_WR_RANGE];
    nxt_errRdRange = fgWrEn ? fgWrData[`PSF_ERR_RD_RANGE] : status_ff[`PSF_ERR_RD_RANGE];
    if (rangeCheckDisInstr) begin
      nxt_errWrRange = 1'b0;
      nxt_errRdRange = 1'b0;
    end
    if (wrRangeHit)
      nxt_errWrRange = 1'b1;
    if (rdRangeHit)
      nxt_errRdRange = 1'b1;
  end

  // Local memory parity: one sticky flag per processor module
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gLmem
      assign nxt_errLmem[g] = lmemParityErr[g] |
                              (fgWrEn ? fgWrData[`PSF_ERR_LMEM_LO + g]
                                      : status_ff[`PSF_ERR_LMEM_LO + g]);
    end
  endgenerate

  // Exit flag and parameter, loaded together by the exit
  always @* begin
    nxt_exitFlag = fgWrEn ? fgWrData[`PSF_EXIT_FLAG] : status_ff[`PSF_EXIT_FLAG];
    nxt_exitParm = fgWrEn ? fgWrData[`PSF_EXIT_PARM_HI:0]
                          : status_ff[`PSF_EXIT_PARM_HI:0];
    if (exitInstr) begin
      nxt_exitFlag = 1'b1;
      nxt_exitParm = exitJk;
    end
  end

  // Word assembly from the field values
  always @* begin
    nxt_status = 32'h0000_0000;
    nxt_status[`PSF_SYS_MODE]                     = nxt_sysMode;
    nxt_status[`PSF_IE_STACK]                     = nxt_ieStack;
    nxt_status[`PSF_ERR_STACK]                    = nxt_errStack;
    nxt_status[`PSF_SEM_VAL]                      = nxt_semVal;
    nxt_status[`PSF_SEM_PTR_HI:`PSF_SEM_PTR_LO]   = nxt_semPtr;
    nxt_status[`PSF_IDLE]                         = nxt_idleBit;
    nxt_status[`PSF_CLK_ENTRY]                    = nxt_clkEntry;
    nxt_status[`PSF_IE_RECIP]                     = nxt_ieRecip;
    nxt_status[`PSF_ERR_RECIP]                    = nxt_errRecip;
    nxt_status[`PSF_FLT_EN]                       = nxt_fltEn;
    nxt_status[`PSF_IE_FLT]                       = nxt_ieFlt;
    nxt_status[`PSF_ERR_FLT]                      = nxt_errFlt;
    nxt_status[`PSF_IE_RANGE]                     = nxt_ieRange;
    nxt_status[`PSF_ERR_WR_RANGE]                 = nxt_errWrRange;
    nxt_status[`PSF_ERR_RD_RANGE]                 = nxt_errRdRange;
    nxt_status[`PSF_IE_LMEM]                      = nxt_ieLmem;
    nxt_status[`PSF_ERR_LMEM_HI:`PSF_ERR_LMEM_LO] = nxt_errLmem;
    nxt_status[`PSF_IE_EXIT]                      = nxt_ieExit;
    nxt_status[`PSF_EXIT_FLAG]                    = nxt_exitFlag;
    nxt_status[`PSF_EXIT_PARM_HI:0]               = nxt_exitParm;
  end

  // Semaphore index; small systems count in bits 27:24 only
  // so the index runs 0..15 and bit 23 plays no part
  always @* begin
    if (smallSystem)
      nxt_semSelect = {1'b0, nxt_semPtr[4:1]};
    else
      nxt_semSelect = nxt_semPtr;
  end

  // Out-of-range reads return zeros instead of memory data
  always @* begin
    if (rdRangeHit)
      nxt_cmRdData = 64'h0;
    else
      nxt_cmRdData = cmRdDataIn;
  end

  // Call request from the updated word, so it tracks each clock
  always @* begin
    nxt_call = (nxt_status[`PSF_ERR_STACK] & nxt_status[`PSF_IE_STACK])
             | (nxt_status[`PSF_ERR_RECIP] & nxt_status[`PSF_IE_RECIP])
             | (nxt_status[`PSF_ERR_FLT] & nxt_status[`PSF_IE_FLT])
             | ((nxt_status[`PSF_ERR_WR_RANGE] | nxt_status[`PSF_ERR_RD_RANGE])
                & nxt_status[`PSF_IE_RANGE])
             | ((|nxt_status[`PSF_ERR_LMEM_HI:`PSF_ERR_LMEM_LO])
                & nxt_status[`PSF_IE_LMEM])
             | (nxt_status[`PSF_EXIT_FLAG] & nxt_status[`PSF_IE_EXIT]
                & nxt_status[`PSF_IDLE]);
  end

  // State and registered outputs
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_ff      <= `PSF_RESET_VAL;
      idle_ff        <= 1'b1;
      statusRdData   <= `PSF_RESET_VAL;
      chanCallReq    <= 1'b0;
      cmWrAllow      <= 1'b0;
      cmRdDataOut    <= 64'h0;
      semSelect      <= 5'h0;
      semWrSel       <= 1'b0;
      clockLoadEn    <= 1'b0;
      fltCheckEnable <= 1'b0;
      errCapture     <= 1'b0;
    end else if (clkEn) begin
      status_ff      <= nxt_status;
      idle_ff        <= nxt_idle;
      statusRdData   <= nxt_status;
      chanCallReq    <= nxt_call;
      cmWrAllow      <= cmWrReq & ~cmAddrOutRange;
      cmRdDataOut    <= nxt_cmRdData;
      semSelect      <= nxt_semSelect;
      semWrSel       <= semSetIn;
      clockLoadEn    <= clockLoadInstr & status_ff[`PSF_CLK_ENTRY];
      fltCheckEnable <= nxt_status[`PSF_FLT_EN];
      errCapture     <= stackParityErr;
    end
  end

endmodule // psf_status_flags

// file: dv/psf_sf_asserts.sv
`timescale 1ns/1ps
// Ties status outputs other than cmRdDataOut, semSelect and fltCheckEnable to the inputs that caused them
module psf_sf_asserts (
  input wire        ref_clk, rst, clkEn, fgWrEn, cpuActive, exitInstr, // Control
  input wire        stackParityErr, errCapture, chanCallReq, semSetIn, semWrSel, // Flags
  input wire        cmWrReq, cmAddrOutRange, cmWrAllow, clockLoadInstr, clockLoadEn, // Refs
  input wire [31:0] fgWrData, statusRdData, // Words
  input wire [5:0]  exitJk // Exit field
);
  wire [31:0] s = statusRdData;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Call request follows the word it launches with, so no lag is allowed
  property p_call;
    chanCallReq == (s[29] & s[30] | s[19] & s[20] | s[16] & s[17] | (s[13] | s[14]) & s[15]
      | (|s[11:8]) & s[12] | s[6] & s[7] & s[22]);
  endproperty
  a_call: assert property (p_call) else $error("call");
  property p_stk; stackParityErr && clkEn |=> s[29] && errCapture; endproperty
  a_stk: assert property (p_stk) else $error("stack");
  property p_wr; cmWrReq && cmAddrOutRange && clkEn |=> !cmWrAllow && s[14]; endproperty
  a_wr: assert property (p_wr) else $error("write range");
  property p_rtc; clockLoadInstr && clkEn && !fgWrEn |=> clockLoadEn == $past(s[21]); endproperty
  a_rtc: assert property (p_rtc) else $error("clock load");
  property p_sem; semSetIn && clkEn |=> semWrSel; endproperty
  a_sem: assert property (p_sem) else $error("semaphore");
  property p_idle; clkEn && !cpuActive |=> s[22]; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_mode; fgWrEn && clkEn |=> s[31] == $past(fgWrData[31]); endproperty
  a_mode: assert property (p_mode) else $error("mode");
  property p_exit; exitInstr && clkEn |=> s[6] && s[22] && s[5:0] == $past(exitJk); endproperty
  a_exit: assert property (p_exit) else $error("exit");
  // Main scenarios
  c_call: cover property (chanCallReq);
  c_exit: cover property (exitInstr ##1 s[6]);
  c_wr: cover property (cmWrReq && cmAddrOutRange);
endmodule // psf_sf_asserts
bind psf_status_flags psf_sf_asserts u_psf_sf_asserts (.*);

// file: dv/psf_fg_model.sv
`timescale 1ns/1ps
// Foreground side: writes the whole status word in one cycle
module psf_fg_model (
  input  wire        ref_clk,  // Clock
  output reg         fgWrEn,   // Write strobe
  output reg  [31:0] fgWrData  // Write word
);
  initial fgWrEn = 1'h0;
  initial fgWrData = 32'h0;
  // Pointer rides in bits 27:23; stale data is inverted so it is never mistaken for live
  task wr(input [31:0] d);
    @(negedge ref_clk);
    fgWrEn = 1'h1;
    fgWrData = d;
    @(negedge ref_clk);
    fgWrEn = 1'h0;
    fgWrData = ~d;
  endtask
endmodule // psf_fg_model

// file: dv/tb_processor_status_flags.sv
`timescale 1ns/1ps
module tb_processor_status_flags;
  reg ref_clk = 1'h0, rst = 1'h1, clkEn = 1'h1, smallSystem = 1'h1, cpuActive = 1'h0;
  reg fgStop, fgRestart, exitInstr, stackParityErr, recipParityErr, fltRangeErr, cmWrReq;
  reg floatCheckDisInstr, floatCheckEnInstr, rangeCheckDisInstr, rangeCheckEnInstr, cmRdReq;
  reg semOwnSet, semOwnClr, semSetIn, clockLoadInstr, cmAddrOutRange = 1'h0;
  reg [3:0] lmemParityErr;
  reg [5:0] exitJk = 6'h0;
  reg [63:0] cmRdDataIn = 64'h0123_4567_89ab_cdef;
  wire fgWrEn, chanCallReq, cmWrAllow, semWrSel, clockLoadEn, fltCheckEnable, errCapture;
  wire [31:0] fgWrData, statusRdData;
  wire [63:0] cmRdDataOut;
  wire [4:0] semSelect;
  integer n_errors = 0, cmp_count = 0;
  psf_fg_model u_psf_fg_model (.ref_clk(ref_clk), .fgWrEn(fgWrEn), .fgWrData(fgWrData));
  psf_status_flags u_psf_status_flags (.*);
  initial forever #10 ref_clk = ~ref_clk;
  // Strobes live one cycle; outputs are judged at the falling edge after
  task zero;
    {fgStop, fgRestart, exitInstr, stackParityErr, recipParityErr, fltRangeErr, cmWrReq,
     floatCheckDisInstr, floatCheckEnInstr, rangeCheckDisInstr, rangeCheckEnInstr, cmRdReq,
     semOwnSet, semOwnClr, semSetIn, clockLoadInstr, lmemParityErr} = 20'h0;
  endtask
  task go;
    @(negedge ref_clk);
    zero;
  endtask
  task chk(input string n, input [63:0] s, input [63:0] e);
    cmp_count = cmp_count + 1;
    if (s !== e) begin
      n_errors = n_errors + 1;
      $display("ERROR %0s expected %h seen %h", n, e, s);
    end
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task t_stack;
    chk("status", statusRdData, 32'h0040_0000);
    u_psf_fg_model.wr(32'hc000_0000);
    chk("call", chanCallReq, 1'h0);
    @(negedge ref_clk); stackParityErr = 1'h1; go;
    chk("status", statusRdData, 32'he040_0000);
    chk("call", chanCallReq, 1'h1);
    chk("capture", errCapture, 1'h1);
    $display("stack test done");
  endtask
  task t_range;
    u_psf_fg_model.wr(32'h0000_8000);
    @(negedge ref_clk); cmAddrOutRange = 1'h1; cmWrReq = 1'h1; go;
    chk("wallow", cmWrAllow, 1'h0);
    @(negedge ref_clk); cmRdReq = 1'h1; go;
    chk("rdata", cmRdDataOut, 64'h0);
    chk("status", statusRdData, 32'h0040_e000);
    chk("call", chanCallReq, 1'h1);
    @(negedge ref_clk); cmAddrOutRange = 1'h0; cmWrReq = 1'h1; rangeCheckDisInstr = 1'h1; go;
    chk("wallow", cmWrAllow, 1'h1);
    chk("status", statusRdData, 32'h0040_0000);
    chk("rdata", cmRdDataOut, 64'h0123_4567_89ab_cdef);
    @(negedge ref_clk); rangeCheckEnInstr = 1'h1; go;
    chk("status", statusRdData, 32'h0040_8000);
    $display("range test done");
  endtask
  task t_exit;
    u_psf_fg_model.wr(32'h0000_0080);
    @(negedge ref_clk); fgRestart = 1'h1; cpuActive = 1'h1; go;
    chk("busy", statusRdData, 32'h0000_0080);
    @(negedge ref_clk); exitJk = 6'h2d; exitInstr = 1'h1; go;
    chk("status", statusRdData, 32'h0040_00ed);
    chk("call", chanCallReq, 1'h1);
    @(negedge ref_clk); fgRestart = 1'h1; go;
    chk("idle", statusRdData[22], 1'h0);
    cpuActive = 1'h0;
    $display("exit test done");
  endtask
  task t_clock;
    u_psf_fg_model.wr(32'h0000_0000);
    @(negedge ref_clk); clockLoadInstr = 1'h1; go;
    chk("load", clockLoadEn, 1'h0);
    u_psf_fg_model.wr(32'h0fa0_0000);
    chk("pointer", semSelect, 5'h0f);
    smallSystem = 1'h0; go;
    chk("pointer", semSelect, 5'h1f);
    @(negedge ref_clk); clockLoadInstr = 1'h1; floatCheckEnInstr = 1'h1; semSetIn = 1'h1; go;
    chk("load", clockLoadEn, 1'h1);
    chk("float", fltCheckEnable, 1'h1);
    chk("semop", semWrSel, 1'h1);
    $display("clock test done");
  endtask
  task t_flags;
    u_psf_fg_model.wr(32'h0012_1000);
    chk("call", chanCallReq, 1'h0);
    @(negedge ref_clk); recipParityErr = 1'h1; go;
    chk("status", statusRdData, 32'h005a_1000);
    chk("call", chanCallReq, 1'h1);
    u_psf_fg_model.wr(32'h0012_1000);
    @(negedge ref_clk); fltRangeErr = 1'h1; go;
    chk("status", statusRdData, 32'h0053_1000);
    chk("call", chanCallReq, 1'h1);
    u_psf_fg_model.wr(32'h0012_1000);
    @(negedge ref_clk); lmemParityErr = 4'h4; go;
    chk("status", statusRdData, 32'h0052_1400);
    chk("call", chanCallReq, 1'h1);
    @(negedge ref_clk); semOwnSet = 1'h1; go;
    chk("sem", statusRdData[28], 1'h1);
    u_psf_fg_model.wr(32'h0000_0000);
    chk("sem", statusRdData[28], 1'h1);
    @(negedge ref_clk); semOwnClr = 1'h1; go;
    chk("sem", statusRdData[28], 1'h0);
    @(negedge ref_clk); fgRestart = 1'h1; cpuActive = 1'h1; go;
    chk("idle", statusRdData[22], 1'h0);
    @(negedge ref_clk); fgStop = 1'h1; go;
    chk("idle", statusRdData[22], 1'h1);
    cpuActive = 1'h0;
    @(negedge ref_clk); clkEn = 1'h0; stackParityErr = 1'h1; go;
    chk("frozen", statusRdData[29], 1'h0);
    clkEn = 1'h1;
    $display("flags test done");
  endtask
  initial begin
    zero;
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk); rst = 1'h0;
    t_stack;
    t_range;
    t_exit;
    t_clock;
    t_flags;
    final_report;
  end
endmodule // tb_processor_status_flags
